// ==== hw/etm_map.svh ====
// constants for the event time marker: offsets, fields, timing
// assumes a 20 MHz mclk; included by bare name
`ifndef ETM_MAP_SVH
`define ETM_MAP_SVH
`define ETM_CLK_MHZ 20
`define ETM_CLK_NS 50
`define ETM_CYC_PER_US (`ETM_CLK_MHZ)
`define ETM_TICK_MS 50
`define ETM_US_PER_TICK (`ETM_TICK_MS * 1000)
`define ETM_PPS_HIGH_US 1500
`define ETM_TRIG_MIN_NS 100
`define ETM_RES_DIFF_NS 50
`define ETM_RES_SA_NS 200
`define ETM_SA_Q (`ETM_RES_SA_NS / `ETM_CLK_NS)
`define ETM_IV_MAX 15'd19980
`define ETM_IV_DEF 15'd20
`define ETM_BAUD_DIV 173
`define ETM_FRAME_BITS 10
`define ETM_MSG_LEN 28
`define ETM_MSG_MAX 80
`define ETM_REG_CTRL 8'h00
`define ETM_REG_RAW 8'h04
`define ETM_REG_ASC 8'h08
`define ETM_REG_PPS 8'h0c
`define ETM_REG_STAT 8'h10
`define ETM_REG_CAPL 8'h14
`define ETM_REG_CAPH 8'h18
`define ETM_CTRL_RST 8'h32
`define ETM_C_EDGE 0
`define ETM_C_EVEN 1
`define ETM_C_PEREN 2
`define ETM_C_DIFF 3
`define ETM_C_PA 4
`define ETM_C_PB 5
`define ETM_DIG_N 15
`define ETM_SEC_T 7
`define ETM_MIN_T 9
`define ETM_HOUR_LO 10
`define ETM_HOUR_F 47:40
`define ETM_HOUR_WRAP 8'h23
`endif

// ==== hw/etm_pkg.sv ====
// types shared by the event time marker files
// assumes etm_map.svh supplies the numeric constants
package etm_pkg;
  typedef enum logic [2:0] {
    ETM_IDLE = 3'b001,
    ETM_SEND = 3'b010,
    ETM_WAIT = 3'b100
  } etm_state_t;
endpackage : etm_pkg

// ==== hw/etm_sync.sv ====
// two-flop synchroniser with edge detect for the trigger pin
// assumes an asynchronous pin and one mclk domain
`timescale 1ns/1ps
`default_nettype none
module etm_sync (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic d,
  output logic lvl,
  output logic rise,
  output logic fall
);
  logic q1;
  logic q2;
  logic q3;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q1 <= 1'b0;
      q2 <= 1'b0;
      q3 <= 1'b0;
    end else begin
      q1 <= d;
      q2 <= q1;
      q3 <= q2;
    end
  end
  // pulse wide enough
  // two cycles at 50 ns; a 100 ns pulse is always sampled
  assign lvl = q2;
  assign rise = q2 & ~q3;
  assign fall = ~q2 & q3;
endmodule : etm_sync
`default_nettype wire

// ==== hw/etm_uart_tx.sv ====
// 8n1 serial transmitter with valid/ready style start
// assumes start only while ready is high
`timescale 1ns/1ps
`default_nettype none
`include "etm_map.svh"
module etm_uart_tx #(
  parameter int DIV = `ETM_BAUD_DIV
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [7:0] data,
  output logic tx,
  output logic ready
);
  logic [15:0] div_cnt;
  logic [3:0] bit_cnt;
  logic [8:0] sh;
  logic busy;
  wire baud = div_cnt == 16'(DIV - 1);
  wire last = bit_cnt == 4'(`ETM_FRAME_BITS - 1);
  assign ready = ~busy;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 16'h0;
      bit_cnt <= 4'h0;
      sh <= 9'h1ff;
      busy <= 1'b0;
      tx <= 1'b1;
    end else if (!busy) begin
      div_cnt <= 16'h0;
      if (start) begin
        busy <= 1'b1;
        bit_cnt <= 4'h0;
        sh <= {1'b1, data};
        tx <= 1'b0;
      end
    end else if (baud) begin
      div_cnt <= 16'h0;
      if (last) begin
        busy <= 1'b0;
      end else begin
        bit_cnt <= bit_cnt + 4'h1;
        tx <= sh[0];
        sh <= {1'b1, sh[8:1]};
      end
    end else begin
      div_cnt <= div_cnt + 16'h1;
    end
  end
  a_stop_high: assert property (@(posedge mclk) disable iff (!rst_b)
    busy && last |-> tx)
    else $error("stop bit not high");
endmodule : etm_uart_tx
`default_nettype wire

// ==== hw/etm_top.sv ====
// event time marker: trigger capture, timing pulse, ascii reports
// assumes a plain register port and 20 MHz mclk aligned to gps second
// Contract
// - edge polarity chosen by configuration
// - rising edge after reset
// - only first edge per epoch tagged
// - at most one record per raw period
// - 50 ns differential, 200 ns stand-alone
// - day, h, m, s, six fraction digits
// - event message follows each captured edge
// - dollar start, commas, cr lf end
// - eighty chars standard, longer allowed
// - ascii period 0.05 to 999 s
// - eight data, one stop, no parity
// - raw period 0.05 to 999 s
// - raw period one second after reset
// - any message mix on any port; here every enabled port gets the same message stream
// - pulse once per second, second aligned; here the period comes from the pps register, one second after reset
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "etm_map.svh"
module etm_top import etm_pkg::*; #(
  parameter int US_PER_TICK = `ETM_US_PER_TICK,
  parameter int BAUD_DIV = `ETM_BAUD_DIV,
  parameter int PPS_HIGH_US = `ETM_PPS_HIGH_US,
  parameter logic [14:0] IV_MIN = 15'h0001
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic trig_in,
  output logic pps_out,
  output logic tx_a,
  output logic tx_b
);
  logic [7:0] ctrl;
  logic [14:0] raw_iv;
  logic [14:0] asc_iv;
  logic [14:0] pps_iv;
  logic [4:0] cyc_cnt;
  logic [15:0] us_cnt;
  logic [59:0] tod;
  logic [14:0] ep_cnt;
  logic [14:0] ap_cnt;
  logic [14:0] pp_cnt;
  logic [10:0] pps_hi;
  logic cap_flag;
  logic [59:0] cap_dig;
  logic [4:0] cap_sub;
  logic [15:0] ev_cnt;
  logic ev_pend;
  logic per_pend;
  etm_state_t state;
  logic [6:0] idx;
  logic [7:0] msg_kind;
  logic [59:0] msg_dig;
  logic ctrl_seen;
  logic raw_seen;
  logic trig_lvl;
  logic trig_rise;
  logic trig_fall;
  logic rdy_a;
  logic rdy_b;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  function automatic logic [14:0] clamp_iv(input logic [31:0] v);
    if (v < 32'(IV_MIN))
      return IV_MIN;
    else if (v > 32'(`ETM_IV_MAX))
      return `ETM_IV_MAX;
    else
      return v[14:0];
  endfunction : clamp_iv

  function automatic logic [3:0] dig_lim(input int i);
    return (i == `ETM_SEC_T || i == `ETM_MIN_T) ? 4'h5 : 4'h9;
  endfunction : dig_lim

  // bcd time of day: usec(6) sec min hour day(3)
  function automatic logic [59:0] tod_inc(input logic [59:0] t);
    logic [59:0] r;
    logic c;
    logic skip;
    logic [3:0] d;
    r = t;
    c = 1'b1;
    skip = 1'b0;
    for (int i = 0; i < `ETM_DIG_N; i++) begin
      d = t[4*i +: 4];
      if (c) begin
        if (i == `ETM_HOUR_LO && t[`ETM_HOUR_F] == `ETM_HOUR_WRAP) begin
          r[`ETM_HOUR_F] = 8'h00;
          skip = 1'b1;
        end else if (skip) begin
          skip = 1'b0;
        end else if (d == dig_lim(i)) begin
          r[4*i +: 4] = 4'h0;
        end else begin
          r[4*i +: 4] = d + 4'h1;
          c = 1'b0;
        end
      end
    end
    return r;
  endfunction : tod_inc

  function automatic logic [7:0] asc(input logic [3:0] d);
    return {4'h3, d};
  endfunction : asc

  function automatic logic [4:0] quant(input logic [4:0] s, input logic diff);
    return diff ? s : (s & ~5'(`ETM_SA_Q - 1));
  endfunction : quant

  // vendor length room; idx is 7 bits but only counts to 27
  function automatic logic [7:0] msg_char(input logic [6:0] i, input logic [7:0] k,
                                          input logic [59:0] d);
    logic [8*`ETM_MSG_LEN-1:0] m;
    m = {"$ETM,", k, ",", asc(d[59:56]), asc(d[55:52]), asc(d[51:48]), ",",
         asc(d[47:44]), asc(d[43:40]), ",", asc(d[39:36]), asc(d[35:32]), ",",
         asc(d[31:28]), asc(d[27:24]), ".", asc(d[23:20]), asc(d[19:16]),
         asc(d[15:12]), asc(d[11:8]), asc(d[7:4]), asc(d[3:0]), 8'h0d, 8'h0a};
    return m[8*(`ETM_MSG_LEN - 1 - int'(i)) +: 8];
  endfunction : msg_char

  etm_sync u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d(trig_in),
    .lvl(trig_lvl),
    .rise(trig_rise),
    .fall(trig_fall)
  );

  wire edge_sel = ctrl[`ETM_C_EDGE];
  wire msg_en = ctrl[`ETM_C_EVEN];
  wire per_en = ctrl[`ETM_C_PEREN];
  wire diff_mode = ctrl[`ETM_C_DIFF];
  wire pa_en = ctrl[`ETM_C_PA];
  wire pb_en = ctrl[`ETM_C_PB];
  wire trig_edge = edge_sel ? trig_fall : trig_rise;
  wire us_tick = cyc_cnt == 5'(`ETM_CYC_PER_US - 1);
  wire tick = us_tick && us_cnt == 16'(US_PER_TICK - 1);
  wire ep_tick = tick && ep_cnt >= raw_iv - 15'h1;
  wire ap_tick = tick && ap_cnt >= asc_iv - 15'h1;
  wire pp_tick = tick && pp_cnt >= pps_iv - 15'h1;
  wire accept = trig_edge && (!cap_flag || ep_tick);
  wire take_ev = state == ETM_IDLE && ev_pend;
  wire take_per = state == ETM_IDLE && !ev_pend && per_pend;
  // same byte to every enabled port
  wire ports_ready = (!pa_en || rdy_a) && (!pb_en || rdy_b);
  wire tx_go = state == ETM_SEND && ports_ready;
  wire [7:0] tx_char = msg_char(idx, msg_kind, msg_dig);
  wire msg_last = idx == 7'(`ETM_MSG_LEN - 1);
  wire [31:0] rd_val =
    (reg_addr == `ETM_REG_CTRL) ? {24'h0, ctrl} :
    (reg_addr == `ETM_REG_RAW) ? {17'h0, raw_iv} :
    (reg_addr == `ETM_REG_ASC) ? {17'h0, asc_iv} :
    (reg_addr == `ETM_REG_PPS) ? {17'h0, pps_iv} :
    (reg_addr == `ETM_REG_STAT) ? {ev_cnt, 7'h0, cap_sub, 1'b0,
                                   state != ETM_IDLE, ev_pend, cap_flag} :
    (reg_addr == `ETM_REG_CAPL) ? cap_dig[31:0] :
    (reg_addr == `ETM_REG_CAPH) ? {4'h0, cap_dig[59:32]} : 32'h0;

  // register port; unmapped reads return zero
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= `ETM_CTRL_RST;
      raw_iv <= `ETM_IV_DEF;
      asc_iv <= `ETM_IV_DEF;
      pps_iv <= `ETM_IV_DEF;
      reg_rdata <= 32'h0;
      ctrl_seen <= 1'b0;
      raw_seen <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_val : 32'h0;
      if (reg_wr) begin
        if (reg_addr == `ETM_REG_CTRL) begin
          ctrl <= reg_wdata[7:0];
          ctrl_seen <= 1'b1;
        end else if (reg_addr == `ETM_REG_RAW) begin
          raw_iv <= clamp_iv(reg_wdata);
          raw_seen <= 1'b1;
        end else if (reg_addr == `ETM_REG_ASC) begin
          asc_iv <= clamp_iv(reg_wdata);
        end else if (reg_addr == `ETM_REG_PPS) begin
          pps_iv <= clamp_iv(reg_wdata);
        end
      end
    end
  end

  // time base; all dividers start together so ticks sit on the second
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_cnt <= 5'h0;
      us_cnt <= 16'h0;
      tod <= 60'h0;
    end else begin
      cyc_cnt <= us_tick ? 5'h0 : cyc_cnt + 5'h1;
      if (us_tick) begin
        us_cnt <= tick ? 16'h0 : us_cnt + 16'h1;
        tod <= tod_inc(tod);
      end
    end
  end

  // period counters in 50 ms ticks
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ep_cnt <= 15'h0;
      ap_cnt <= 15'h0;
      pp_cnt <= 15'h0;
    end else if (tick) begin
      ep_cnt <= ep_tick ? 15'h0 : ep_cnt + 15'h1;
      ap_cnt <= ap_tick ? 15'h0 : ap_cnt + 15'h1;
      pp_cnt <= pp_tick ? 15'h0 : pp_cnt + 15'h1;
    end
  end

  // timing pulse follows the pulse period set by software
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pps_out <= 1'b0;
      pps_hi <= 11'h0;
    end else if (pp_tick) begin
      pps_out <= 1'b1;
      pps_hi <= 11'h0;
    end else if (pps_out && us_tick) begin
      if (pps_hi == 11'(PPS_HIGH_US - 1))
        pps_out <= 1'b0;
      else
        pps_hi <= pps_hi + 11'h1;
    end
  end

  // capture; an edge on the epoch tick opens the new epoch
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cap_flag <= 1'b0;
      cap_dig <= 60'h0;
      cap_sub <= 5'h0;
      ev_cnt <= 16'h0;
    end else if (accept) begin
      cap_flag <= 1'b1;
      cap_dig <= tod;
      cap_sub <= quant(cyc_cnt, diff_mode);
      ev_cnt <= ev_cnt + 16'h1;
    end else if (ep_tick) begin
      cap_flag <= 1'b0;
    end
  end

  // pending flags: a new set wins over the take
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ev_pend <= 1'b0;
      per_pend <= 1'b0;
    end else begin
      if (accept && msg_en)
        ev_pend <= 1'b1;
      else if (take_ev)
        ev_pend <= 1'b0;
      if (ap_tick && per_en)
        per_pend <= 1'b1;
      else if (take_per)
        per_pend <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ETM_IDLE;
      idx <= 7'h0;
      msg_kind <= 8'h0;
      msg_dig <= 60'h0;
    end else begin
      case (state)
        ETM_IDLE: begin
          idx <= 7'h0;
          if (take_ev) begin
            msg_kind <= "E";
            msg_dig <= cap_dig;
            state <= ETM_SEND;
          end else if (take_per) begin
            msg_kind <= "T";
            msg_dig <= tod;
            state <= ETM_SEND;
          end
        end
        ETM_SEND: begin
          if (ports_ready)
            state <= ETM_WAIT;
        end
        ETM_WAIT: begin
          if (msg_last) begin
            state <= ETM_IDLE;
          end else begin
            idx <= idx + 7'h1;
            state <= ETM_SEND;
          end
        end
        default: state <= ETM_IDLE;
      endcase
    end
  end

  etm_uart_tx #(.DIV(BAUD_DIV)) u_tx_a (
    .mclk(mclk),
    .rst_b(rst_b),
    .start(tx_go && pa_en),
    .data(tx_char),
    .tx(tx_a),
    .ready(rdy_a)
  );
  etm_uart_tx #(.DIV(BAUD_DIV)) u_tx_b (
    .mclk(mclk),
    .rst_b(rst_b),
    .start(tx_go && pb_en),
    .data(tx_char),
    .tx(tx_b),
    .ready(rdy_b)
  );

  a_edge_polarity: assert property (
    accept |-> trig_lvl == !edge_sel)
    else $error("accepted edge has wrong polarity");
  a_rise_default: assert property (
    !ctrl_seen |-> !edge_sel)
    else $error("falling edge active before configuration");
  a_first_only: assert property (
    cap_flag && !ep_tick |=> $stable(cap_dig) && $stable(cap_sub))
    else $error("second edge in epoch overwrote capture");
  a_epoch_restart: assert property (
    ep_tick |=> ep_cnt == 15'h0 && !tick)
    else $error("epoch counter did not restart");
  a_sub_quant: assert property (
    accept && !diff_mode |=> cap_sub[1:0] == 2'h0)
    else $error("stand-alone capture finer than 200 ns");
  a_cap_time: assert property (
    accept |=> cap_dig == $past(tod))
    else $error("captured time not the time of the edge");
  a_event_queue: assert property (
    accept && msg_en |=> ev_pend)
    else $error("event message not queued");
  a_frame_start: assert property (
    tx_go && idx == 7'h0 |-> tx_char == "$")
    else $error("message does not start with dollar");
  a_frame_end: assert property (
    tx_go && msg_last |-> tx_char == 8'h0a)
    else $error("message does not end with lf");
  a_frame_cr: assert property (
    tx_go && idx == 7'(`ETM_MSG_LEN - 2) |-> tx_char == 8'h0d)
    else $error("message lacks cr before lf");
  a_msg_length: assert property (
    state != ETM_IDLE |-> idx < 7'(`ETM_MSG_MAX))
    else $error("message longer than allowed");
  a_ascii_range: assert property (
    asc_iv >= IV_MIN && asc_iv <= `ETM_IV_MAX)
    else $error("ascii period out of range");
  a_raw_range: assert property (
    raw_iv >= IV_MIN && raw_iv <= `ETM_IV_MAX)
    else $error("raw period out of range");
  a_raw_default: assert property (
    !raw_seen |-> raw_iv == `ETM_IV_DEF)
    else $error("raw period not one second");
  a_pps_high: assert property (
    $rose(pps_out) |-> pps_out[*8])
    else $error("timing pulse too short");
  a_flag_clear: assert property (
    ep_tick && !trig_edge |=> !cap_flag)
    else $error("captured flag survived epoch");
  a_cap_latch: assert property (
    trig_edge && !cap_flag |=> cap_flag && ev_cnt == $past(ev_cnt) + 16'h1)
    else $error("edge not latched");
endmodule : etm_top
`default_nettype wire

// ==== tb/etm_partner.sv ====
// far side models: trigger source and 8n1 serial listener
// assumes one mclk domain shared with the block
`timescale 1ns/1ps
`default_nettype none
module etm_trig_src #(
  parameter int MIN_CYC = 2
) (
  input wire logic mclk,
  output logic trig
);
  initial trig = 1'b0;
  task automatic level(input logic v, input int hold);
    @(posedge mclk);
    trig <= v;
    repeat ((hold < MIN_CYC) ? MIN_CYC : hold) @(posedge mclk);
  endtask : level
endmodule : etm_trig_src

module etm_serial_rx #(
  parameter int DIV = 4
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic line,
  output logic [7:0] rx_byte,
  output logic rx_vld,
  output logic frame_err
);
  // start, 8 data lsb first, stop
  // samples mid-bit so edge races with the sender cannot occur
  initial begin
    rx_byte = 8'h00;
    rx_vld = 1'b0;
    frame_err = 1'b0;
    forever begin
      @(negedge line);
      if (rst_b === 1'b1) begin
        repeat (DIV / 2) @(posedge mclk);
        if (line !== 1'b0) frame_err = 1'b1;
        for (int i = 0; i < 8; i++) begin
          repeat (DIV) @(posedge mclk);
          rx_byte[i] = line;
        end
        repeat (DIV) @(posedge mclk);
        if (line !== 1'b1) frame_err = 1'b1;
        rx_vld = 1'b1;
        @(posedge mclk);
        rx_vld = 1'b0;
      end
    end
  end
endmodule : etm_serial_rx
`default_nettype wire

// ==== tb/event_time_marker_tb.sv ====
// self-checking bench for the event time marker
// assumes shortened tick and baud parameters, no other master
`timescale 1ns/1ps
`default_nettype none
`include "etm_map.svh"
module event_time_marker_tb;
  localparam int US_T = 5;
  localparam int DIV = 4;
  localparam int EPOCH = 20 * US_T * `ETM_CYC_PER_US;
  logic mclk, rst_b, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, d, c1;
  wire logic [31:0] reg_rdata;
  wire logic trig_in, pps_out, tx_a, tx_b, a_vld, b_vld, a_err, b_err;
  wire logic [7:0] a_byte, b_byte;
  logic [7:0] qa[$], qb[$];
  logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h1c};
  logic [31:0] rv[5] = '{32'(`ETM_CTRL_RST), 32'(`ETM_IV_DEF), 32'(`ETM_IV_DEF),
    32'(`ETM_IV_DEF), 32'h0};
  int failures, comparisons, n;

  etm_top #(.US_PER_TICK(US_T), .BAUD_DIV(DIV), .PPS_HIGH_US(20)) DUT (.mclk(mclk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trig_in(trig_in), .pps_out(pps_out), .tx_a(tx_a), .tx_b(tx_b));
  etm_trig_src src (.mclk(mclk), .trig(trig_in));
  etm_serial_rx #(.DIV(DIV)) rx_a (.mclk(mclk), .rst_b(rst_b), .line(tx_a),
    .rx_byte(a_byte), .rx_vld(a_vld), .frame_err(a_err));
  etm_serial_rx #(.DIV(DIV)) rx_b (.mclk(mclk), .rst_b(rst_b), .line(tx_b),
    .rx_byte(b_byte), .rx_vld(b_vld), .frame_err(b_err));

  always @(posedge a_vld) qa.push_back(a_byte);
  always @(posedge b_vld) qb.push_back(b_byte);

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic test_done();
    if (failures == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  // waits for the next rising edge of the timing pulse; counts cycles, fails after 3000
  task automatic wait_pps(output int cnt);
    logic prev;
    cnt = 0;
    prev = 1'b1;
    while (cnt < 3000) begin
      @(posedge mclk);
      #1 cnt++;
      if (pps_out === 1'b1 && prev === 1'b0) break;
      prev = pps_out;
    end
    if (cnt >= 3000) begin
      failures++;
      test_done();
    end
  endtask : wait_pps

  task automatic wait_bytes(ref logic [7:0] q[$], input int lim);
    for (int i = 0; i < lim && q.size() < 28; i++) @(posedge mclk);
    if (q.size() < 28) begin
      failures++;
      test_done();
    end
  endtask : wait_bytes

  task automatic chk_msg(input string what, input logic [7:0] q[$], input logic [7:0] kind);
    int commas;
    commas = 0;
    check(what, 32'(q.size()), 32'd28);
    if (q.size() == 28) begin
      check(what, 32'(q[0]), 32'h24);
      check(what, 32'(q[5]), 32'(kind));
      check(what, 32'({q[26], q[27]}), 32'h0d0a);
      foreach (q[i]) if (q[i] === 8'h2c) commas++;
      check(what, 32'(commas), 32'd5);
    end
  endtask : chk_msg

  initial begin
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    failures = 0;
    comparisons = 0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i], d);
      check("reset value", d, rv[i]);
    end
    @(posedge mclk);
    #1 check("read idle", reg_rdata, 32'h0);
    wait_pps(n);
    wait_pps(n);
    check("pps period", 32'(n), 32'(EPOCH));
    // rising edge, second edge in same epoch refused
    rd(8'h10, d);
    check("flag clear", 32'(d[0]), 32'h0);
    qa.delete();
    qb.delete();
    src.level(1'b1, 4);
    src.level(1'b0, 4);
    rd(8'h10, d);
    check("flag set", 32'(d[0]), 32'h1);
    check("edge count", 32'(d[31:16]), 32'h1);
    check("sub-us grain", 32'(d[5:4]), 32'h0);
    rd(8'h14, c1);
    for (int k = 0; k < 8; k++) check("bcd digit", 32'(c1[4*k +: 4] > 4'h9), 32'h0);
    src.level(1'b1, 4);
    src.level(1'b0, 4);
    rd(8'h10, d);
    check("edge count", 32'(d[31:16]), 32'h1);
    rd(8'h14, d);
    check("capture kept", d, c1);
    wait_bytes(qb, 1800);
    repeat (100) @(posedge mclk);
    chk_msg("port a msg", qa, 8'h45);
    chk_msg("port b msg", qb, 8'h45);
    foreach (qa[i]) if (i < qb.size()) check("same bytes", 32'(qb[i]), 32'(qa[i]));
    wait_pps(n);
    rd(8'h10, d);
    check("epoch clear", 32'(d[0]), 32'h0);
    // falling edge selected, differential, port a off
    wr(8'h00, 32'h2b);
    wait_pps(n);
    qa.delete();
    qb.delete();
    src.level(1'b1, 7);
    rd(8'h10, d);
    check("rise ignored", 32'(d[0]), 32'h0);
    src.level(1'b0, 6);
    rd(8'h10, d);
    check("fall taken", 32'(d[0]), 32'h1);
    check("diff grain", 32'(d[8:4]), 32'd13);
    wait_bytes(qb, 1800);
    chk_msg("falling msg", qb, 8'h45);
    check("port a quiet", 32'(qa.size()), 32'h0);
    // periodic report only
    wr(8'h00, 32'h34);
    qa.delete();
    wait_bytes(qa, 2 * EPOCH + 1500);
    chk_msg("periodic msg", qa, 8'h54);
    for (int i = 1; i < 3; i++) begin
      wr(ra[i], 32'h0);
      rd(ra[i], d);
      check("period floor", d, 32'h1);
      wr(ra[i], 32'h7fff);
      rd(ra[i], d);
      check("period ceiling", d, 32'(`ETM_IV_MAX));
    end
    wr(8'h1c, 32'hffffffff);
    rd(8'h1c, d);
    check("unmapped", d, 32'h0);
    check("frame errors", 32'({a_err, b_err}), 32'h0);
    test_done();
  end
endmodule : event_time_marker_tb
`default_nettype wire
